/* File: include/ris_consts.svh */
// constants for the remappable input selector: offsets, fields, resets
`ifndef RIS_CONSTS_SVH
`define RIS_CONSTS_SVH

// register byte offsets
`define RIS_OFF_TMR32 8'h00
`define RIS_OFF_TMR54 8'h04
`define RIS_OFF_CAP21 8'h08
`define RIS_OFF_CAP43 8'h0C
`define RIS_OFF_CAP65 8'h10
`define RIS_OFF_CAP87 8'h14
`define RIS_OFF_FAULT 8'h18
`define RIS_OFF_CAP9 8'h1C
`define RIS_OFF_SER3 8'h20
`define RIS_OFF_LOCK 8'h24

// field layout
`define RIS_SEL_W 6
`define RIS_HI_LSB 8
`define RIS_LO_LSB 0
`define RIS_LOCK_BIT 6
`define RIS_SEL_RESET 6'h3F

// sizes: selector slots (two per register) and pins present
`define RIS_NSEL 18
`define RIS_PIN_COUNT 48

// bus responses
`define RIS_RESP_OKAY 2'h0
`define RIS_RESP_SLVERR 2'h2

`endif

/* File: include/ris_pkg.sv */
// types of the remappable input selector
package ris_pkg;
`include "ris_consts.svh"

    typedef logic [`RIS_SEL_W-1:0] ris_sel_t;

    // whole state of the block, registered as one word
    typedef struct packed {
        logic [`RIS_PIN_COUNT-1:0] s1;
        logic [`RIS_PIN_COUNT-1:0] s2;
        logic [`RIS_PIN_COUNT-1:0] s3;
        logic [`RIS_PIN_COUNT-1:0] pin;
        ris_sel_t [`RIS_NSEL-1:0] sel;
        logic lock;
        logic [`RIS_NSEL-1:0] routed;
        logic awrdy;
        logic aw_held;
        logic [7:0] awaddr;
        logic wrdy;
        logic w_held;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [15:0] rdata;
    } ris_state_t;
endpackage

/* File: rtl/ris_top.sv */
// remappable input selector: axi4-lite registers and pin-to-input routing
`timescale 1ns/1ns
`include "ris_consts.svh"
module ris_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite slave
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // remappable pins, asynchronous to aclk
    input wire logic [`RIS_PIN_COUNT-1:0] remappable_pin,
    // routed peripheral inputs
    output logic timer2_external_clock,
    output logic timer3_external_clock,
    output logic timer4_external_clock,
    output logic timer5_external_clock,
    output logic capture_channel_1,
    output logic capture_channel_2,
    output logic capture_channel_3,
    output logic capture_channel_4,
    output logic capture_channel_5,
    output logic capture_channel_6,
    output logic capture_channel_7,
    output logic capture_channel_8,
    output logic capture_channel_9,
    output logic compare_fault_a,
    output logic compare_fault_b,
    output logic serial3_receive
);
    import ris_pkg::*;

    // reset image: selectors all ones, everything else clear
    localparam ris_state_t RST = '{sel: {`RIS_NSEL{`RIS_SEL_RESET}}, default: '0};

    ris_state_t q; // registered state
    ris_state_t d; // next state
    logic [3:0] widx; // word index of the held write address
    logic wmapped; // held write address hits a register
    logic [3:0] ridx; // word index of the read address
    logic rmapped; // read address hits a register
    logic [`RIS_PIN_COUNT-1:0] agree; // second and third sync stages equal

    // pick a settled pin; numbers past the last pin read as ground
    function automatic logic pick
    (
        input ris_sel_t s,
        input logic [`RIS_PIN_COUNT-1:0] p
    );
        logic r;
        r = 1'b0;
        if (s < `RIS_PIN_COUNT)
        begin
            r = p[s];
        end
        return r;
    endfunction

    // next-state logic for pins, routing and the bus slave
    always_comb
    begin
        d = q;
        widx = q.awaddr[5:2];
        wmapped = (q.awaddr[1:0] == 2'h0) && (q.awaddr <= `RIS_OFF_LOCK);
        ridx = araddr[5:2];
        rmapped = (araddr[1:0] == 2'h0) && (araddr <= `RIS_OFF_LOCK);
        agree = ~(q.s2 ^ q.s3);

        // three-stage synchroniser; the first stage feeds only the second
        d.s1 = remappable_pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // a pin level counts only once stages two and three agree
        d.pin = (q.s3 & agree) | (q.pin & ~agree);

        // registered routing, one cycle behind the settled pins
        for (int k = 0; k < `RIS_NSEL; k++)
        begin
            d.routed[k] = pick(q.sel[k], q.pin);
        end

        // write address and data are taken independently
        if (awvalid && q.awrdy)
        begin
            d.aw_held = 1'b1;
            d.awaddr = awaddr;
        end
        if (wvalid && q.wrdy)
        begin
            d.w_held = 1'b1;
            d.wdata = wdata[15:0];
            d.wstrb = wstrb[1:0];
        end

        // both halves present: perform the write and answer
        if (q.aw_held && q.w_held && !q.bvalid)
        begin
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `RIS_RESP_OKAY;
            if (!wmapped)
            begin
                d.bresp = `RIS_RESP_SLVERR;
            end
            else if (q.awaddr == `RIS_OFF_LOCK)
            begin
                // lock itself stays writable so software can unlock
                if (q.wstrb[0])
                begin
                    d.lock = q.wdata[`RIS_LOCK_BIT];
                end
            end
            else if (!q.lock)
            begin
                // upper selector in bits 13-8 of every register
                if (q.wstrb[1])
                begin
                    d.sel[{widx, 1'b1}] = q.wdata[`RIS_HI_LSB +: `RIS_SEL_W];
                end
                // lower selector only below the single-selector registers
                if (q.wstrb[0] && (q.awaddr < `RIS_OFF_CAP9))
                begin
                    d.sel[{widx, 1'b0}] = q.wdata[`RIS_LO_LSB +: `RIS_SEL_W];
                end
            end
        end
        if (q.bvalid && bready)
        begin
            d.bvalid = 1'b0;
        end
        // a new write waits until the response has gone
        d.awrdy = !d.aw_held && !d.bvalid;
        d.wrdy = !d.w_held && !d.bvalid;

        // read: one at a time, answered the cycle after acceptance
        if (arvalid && q.arrdy)
        begin
            d.rvalid = 1'b1;
            d.rdata = 16'h0000;
            d.rresp = `RIS_RESP_OKAY;
            if (!rmapped)
            begin
                d.rresp = `RIS_RESP_SLVERR;
            end
            else if (araddr == `RIS_OFF_LOCK)
            begin
                d.rdata[`RIS_LOCK_BIT] = q.lock;
            end
            else
            begin
                d.rdata[`RIS_HI_LSB +: `RIS_SEL_W] = q.sel[{ridx, 1'b1}];
                if (araddr < `RIS_OFF_CAP9)
                begin
                    d.rdata[`RIS_LO_LSB +: `RIS_SEL_W] = q.sel[{ridx, 1'b0}];
                end
            end
        end
        if (q.rvalid && rready)
        begin
            d.rvalid = 1'b0;
        end
        d.arrdy = !d.rvalid;
    end

    // single state register; clock enable freezes everything except the synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= RST;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    // outputs come straight from the state register
    assign awready = q.awrdy;
    assign wready = q.wrdy;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arrdy;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = {16'h0000, q.rdata};
    assign timer2_external_clock = q.routed[0];
    assign timer3_external_clock = q.routed[1];
    assign timer4_external_clock = q.routed[2];
    assign timer5_external_clock = q.routed[3];
    assign capture_channel_1 = q.routed[4];
    assign capture_channel_2 = q.routed[5];
    assign capture_channel_3 = q.routed[6];
    assign capture_channel_4 = q.routed[7];
    assign capture_channel_5 = q.routed[8];
    assign capture_channel_6 = q.routed[9];
    assign capture_channel_7 = q.routed[10];
    assign capture_channel_8 = q.routed[11];
    assign compare_fault_a = q.routed[12];
    assign compare_fault_b = q.routed[13];
    assign capture_channel_9 = q.routed[15];
    assign serial3_receive = q.routed[17];
    // slots 14 and 16 have no selector; prot bits carry no meaning here

    // timer2 follows the pin named by the low field of the first register
    timer_lo_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[0] < `RIS_PIN_COUNT |=> timer2_external_clock == $past(q.pin[q.sel[0]]))
        else $error("timer2 clock not routed from its selected pin");

    // timer5 follows the pin named by the high field of the second register
    timer_hi_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[3] < `RIS_PIN_COUNT |=> timer5_external_clock == $past(q.pin[q.sel[3]]))
        else $error("timer5 clock not routed from its selected pin");

    // capture 2 from the high field while its selector holds still
    capture_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && $stable(q.sel[5]) && q.sel[5] < `RIS_PIN_COUNT ##1 ce && $stable(q.sel[5])
        |=> capture_channel_2 == $past(q.pin[q.sel[5]]))
        else $error("capture 2 not routed from its selected pin");

    // serial receive follows the high field of its register
    serial_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[17] < `RIS_PIN_COUNT |=> serial3_receive == $past(q.pin[q.sel[17]]))
        else $error("serial receive not routed from its selected pin");

    // every selector is all ones right after reset
    reset_ones_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> q.sel == {`RIS_NSEL{`RIS_SEL_RESET}} && !q.lock)
        else $error("selectors not all ones after reset");

    // unimplemented bits of a selector register read back zero
    read_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && arvalid && arready && araddr < `RIS_OFF_LOCK
        |=> rvalid && rdata[31:14] == 18'h0 && rdata[7:6] == 2'h0)
        else $error("unimplemented bits read nonzero");

    // all-ones selection grounds the fault input one edge later
    ground_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[13] == `RIS_SEL_RESET |=> !compare_fault_b)
        else $error("all-ones selector did not ground fault B");

    // locked writes leave every selector untouched
    lock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.lock && q.aw_held && q.w_held && !q.bvalid |=> q.sel == $past(q.sel))
        else $error("selector changed while locked");

    // absent pin numbers give a low capture 9 input
    absent_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[15] >= `RIS_PIN_COUNT |=> !capture_channel_9)
        else $error("absent pin did not give a low level");

    // a write is answered one edge after both halves are held
    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.aw_held && q.w_held && !q.bvalid |=> bvalid && !awready && !wready)
        else $error("write response missing");

    // timer3 follows the pin named by the high field of the first register
    timer3_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[1] < `RIS_PIN_COUNT
        |=> timer3_external_clock == $past(q.pin[q.sel[1]]))
        else $error("timer3 clock not routed from its selected pin");

    // timer4 follows the pin named by the low field of the second register
    timer4_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[2] < `RIS_PIN_COUNT
        |=> timer4_external_clock == $past(q.pin[q.sel[2]]))
        else $error("timer4 clock not routed from its selected pin");

    // capture 1 follows the low field of the first capture register
    capture1_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[4] < `RIS_PIN_COUNT
        |=> capture_channel_1 == $past(q.pin[q.sel[4]]))
        else $error("capture 1 not routed from its selected pin");

    // capture 4 follows the high field of the second capture register
    capture4_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[7] < `RIS_PIN_COUNT
        |=> capture_channel_4 == $past(q.pin[q.sel[7]]))
        else $error("capture 4 not routed from its selected pin");

    // capture 5 follows the low field of the third capture register
    capture5_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[8] < `RIS_PIN_COUNT
        |=> capture_channel_5 == $past(q.pin[q.sel[8]]))
        else $error("capture 5 not routed from its selected pin");

    // capture 6 follows the high field of the third capture register
    capture6_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[9] < `RIS_PIN_COUNT
        |=> capture_channel_6 == $past(q.pin[q.sel[9]]))
        else $error("capture 6 not routed from its selected pin");

    // capture 7 follows the low field of the fourth capture register
    capture7_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[10] < `RIS_PIN_COUNT
        |=> capture_channel_7 == $past(q.pin[q.sel[10]]))
        else $error("capture 7 not routed from its selected pin");

    // capture 8 follows the high field of the fourth capture register
    capture8_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[11] < `RIS_PIN_COUNT
        |=> capture_channel_8 == $past(q.pin[q.sel[11]]))
        else $error("capture 8 not routed from its selected pin");

    // fault A follows the low field of the fault register
    fault_low_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[12] < `RIS_PIN_COUNT
        |=> compare_fault_a == $past(q.pin[q.sel[12]]))
        else $error("fault A not routed from its selected pin");

    // capture 9 follows the only field of its register
    capture9_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && q.sel[15] < `RIS_PIN_COUNT
        |=> capture_channel_9 == $past(q.pin[q.sel[15]]))
        else $error("capture 9 not routed from its selected pin");

    // a low clock enable holds every flop, bus and routing alike
    freeze_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ce
        |=> q == $past(q))
        else $error("state moved while clock enable low");

    // a read of the first register returns both of its selectors
    read_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && arvalid && arready && araddr == `RIS_OFF_TMR32
        |=> rdata[15:0] == {2'b00, $past(q.sel[1]), 2'b00, $past(q.sel[0])})
        else $error("first register did not read back its selectors");

    // an unlocked full-word write to the fault register lands in both fields
    fault_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !q.lock && q.aw_held && q.w_held && !q.bvalid && q.awaddr == `RIS_OFF_FAULT
        && q.wstrb == 2'h3
        |=> q.sel[13] == $past(q.wdata[13:8]) && q.sel[12] == $past(q.wdata[5:0]))
        else $error("fault register write did not land");
endmodule

/* File: test/ris_pin_model.sv */
// behavioural model of the remappable pins feeding the selector
`timescale 1ns/1ns
`include "ris_consts.svh"
module ris_pin_model
(
    input wire logic aclk,
    input wire logic [`RIS_PIN_COUNT-1:0] level,
    output logic [`RIS_PIN_COUNT-1:0] remappable_pin
);
    // pins move just after an edge; the block must resynchronise them itself
    // one driver only: unknown until the first edge, while reset holds the block
    always @(posedge aclk)
    begin
        remappable_pin <= level;
    end
endmodule

/* File: test/remappable_input_select_bench.sv */
// self-checking bench: register access and pin routing of ris_top
`timescale 1ns/1ns
`include "ris_consts.svh"
module remappable_input_select_bench;
    import ris_pkg::*;
    logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [2:0] awprot = '0, arprot = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp;
    logic [`RIS_PIN_COUNT-1:0] level = '0, remappable_pin;
    logic timer2_external_clock, timer3_external_clock, timer4_external_clock;
    logic timer5_external_clock, capture_channel_1, capture_channel_2;
    logic capture_channel_3, capture_channel_4, capture_channel_5, capture_channel_6;
    logic capture_channel_7, capture_channel_8, capture_channel_9;
    logic compare_fault_a, compare_fault_b, serial3_receive;
    logic [15:0] outs; // routed inputs, bit 0 = timer2
    logic [5:0] hs, ls;
    int num_errors = 0, n_checks = 0, r, j;
    assign outs = {serial3_receive, capture_channel_9, compare_fault_b, compare_fault_a,
        capture_channel_8, capture_channel_7, capture_channel_6, capture_channel_5,
        capture_channel_4, capture_channel_3, capture_channel_2, capture_channel_1,
        timer5_external_clock, timer4_external_clock, timer3_external_clock,
        timer2_external_clock};
    // 20 MHz clock
    always #25 aclk = ~aclk;
    ris_top dut (.aclk, .aresetn, .ce, .awaddr, .awprot, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .remappable_pin,
        .timer2_external_clock, .timer3_external_clock, .timer4_external_clock,
        .timer5_external_clock, .capture_channel_1, .capture_channel_2,
        .capture_channel_3, .capture_channel_4, .capture_channel_5, .capture_channel_6,
        .capture_channel_7, .capture_channel_8, .capture_channel_9, .compare_fault_a,
        .compare_fault_b, .serial3_receive);
    ris_pin_model pins (.aclk, .level, .remappable_pin);
    // single compare point
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // axi write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        if (n == 200) num_errors++; // no response: a hang counts as a mismatch
        chk(bresp, er);
        bready <= 0;
        @(posedge aclk); // let an edge pass before the next request
    endtask
    // axi read, data and response taken at the rvalid edge
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        if (n == 200) num_errors++;
        chk(rdata, {16'h0000, e});
        chk(rresp, er);
        rready <= 0;
        @(posedge aclk); // let an edge pass before the next request
    endtask
    task automatic settle();
        repeat (8) @(posedge aclk); // pin model edge plus five-edge sync path
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog, well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        level <= '1;
        settle();
        chk(outs, 16'h0000);
        for (r = 0; r < 9; r++)
            rd(8'(4 * r), (r < 7) ? 16'h3F3F : 16'h3F00, 2'h0);
        $display("test reset values done");
        // each output gets its own pin, pin 3*j; spare bits written as ones
        for (r = 0; r < 9; r++)
        begin
            hs = 6'(3 * ((r < 7) ? 2 * r + 1 : r + 7));
            ls = 6'(6 * r);
            wr(8'(4 * r), {2'b11, hs, (r < 7) ? {2'b11, ls} : 8'hFF}, 2'h0);
            rd(8'(4 * r), {2'b00, hs, (r < 7) ? {2'b00, ls} : 8'h00}, 2'h0);
        end
        for (j = 0; j < 16; j++)
        begin
            level <= `RIS_PIN_COUNT'(1) << (3 * j);
            settle();
            chk(outs, 16'(1) << j);
        end
        $display("test routing done");
        // absent pin 48 and the all-ones value both read low
        level <= '1;
        wr(`RIS_OFF_TMR32, 16'h3F30, 2'h0);
        settle();
        chk(outs, 16'hFFFC);
        // locked writes are answered but dropped
        wr(`RIS_OFF_LOCK, 16'h0040, 2'h0);
        wr(`RIS_OFF_TMR32, 16'h0101, 2'h0);
        rd(`RIS_OFF_TMR32, 16'h3F30, 2'h0);
        wr(`RIS_OFF_LOCK, 16'h0000, 2'h0);
        wr(`RIS_OFF_TMR32, 16'h0101, 2'h0);
        rd(`RIS_OFF_TMR32, 16'h0101, 2'h0);
        $display("test lock done");
        // unmapped and misaligned places are refused and store nothing
        wr(8'h28, 16'h0202, 2'h2);
        wr(8'h02, 16'h0202, 2'h2);
        rd(8'h28, 16'h0000, 2'h2);
        rd(`RIS_OFF_TMR32, 16'h0101, 2'h0);
        $display("test unmapped done");
        // clock enable low freezes routing; a mid-run reset restores selectors
        ce <= 0;
        level <= '0;
        settle();
        chk(outs, 16'hFFFF);
        ce <= 1;
        settle();
        chk(outs, 16'h0000);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(`RIS_OFF_TMR32, 16'h3F3F, 2'h0);
        $display("test freeze and reset done");
        report_and_stop();
    end
endmodule
